// *** src/tpp_pkg.sv ***
package tpp_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam int unsigned IDX_W = 16;
  localparam int unsigned BYTE_ADDR_W = IDX_W + 2;
  localparam logic [IDX_W-1:0] IDX_PIN_LEVELS = 16'hf21a;
  localparam logic [IDX_W-1:0] IDX_DIRECTION = 16'hf21b;
  localparam logic [IDX_W-1:0] IDX_MODE_LOW = 16'hf21c;
  localparam logic [IDX_W-1:0] IDX_MODE_HIGH = 16'hf21d;
  localparam logic [IDX_W-1:0] IDX_DRIVE_LEVEL = 16'hf21e;
  localparam logic [IDX_W-1:0] IDX_STATUS = 16'hf21f;

  // Bit positions of the three pins inside the port registers, and of the crystal select bit in the status register
  localparam int unsigned BIT_INPUT_PIN = 2;
  localparam int unsigned BIT_BIDIR_PIN = 3;
  localparam int unsigned BIT_TEST_PIN = 4;
  localparam int unsigned BIT_XTAL_SEL = 0;

  localparam logic [7:0] PIN_FIELD_MASK = 8'h1c;
  localparam logic [7:0] DIR_WRITE_MASK = 8'h18;
  localparam logic [7:0] DRIVE_WRITE_MASK = 8'h18;

  localparam logic [7:0] DIRECTION_RST = 8'h10;
  localparam logic [7:0] MODE_LOW_RST = 8'h10;
  localparam logic [7:0] MODE_HIGH_RST = 8'h00;
  localparam logic [7:0] DRIVE_LEVEL_RST = 8'h00;

  // Two-bit mode code {high register bit, low register bit}
  localparam logic [1:0] MODE_OFF = 2'b00;
  localparam logic [1:0] MODE_PD_PCH = 2'b01;
  localparam logic [1:0] MODE_PU_NCH = 2'b10;
  localparam logic [1:0] MODE_CMOS = 2'b11;

  typedef enum logic {APB_IDLE, APB_ACCESS} tpp_apb_state_t;

  typedef struct packed {
    logic force_hiz;
    logic dir_in;
    logic [1:0] mode;
    logic out_lvl;
  } tpp_pin_ctl_t;

  typedef struct packed {
    logic pull_up;
    logic pull_down;
    logic out;
    logic oe_n;
  } tpp_pin_drv_t;

  localparam tpp_pin_drv_t PIN_DRV_RST = '{1'b0, 1'b0, 1'b0, 1'b1};

  function automatic logic [BYTE_ADDR_W-1:0] byte_addr(
    input logic [IDX_W-1:0] idx
  );
    return {idx, 2'b00};
  endfunction

endpackage

// *** src/tpp_sync.sv ***
`timescale 1ns/1ps
module tpp_sync import tpp_pkg::*; #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  initial begin
    if (WIDTH < 1) $error("tpp_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    stage1_r <= async_in;
    sync_out <= stage1_r;
  end

endmodule

// *** src/tpp_pin_drive.sv ***
`timescale 1ns/1ps
module tpp_pin_drive import tpp_pkg::*; #(
  parameter bit HAS_OUTPUT = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tpp_pin_ctl_t ctl_in,
  output tpp_pin_drv_t drv_out
);

  tpp_pin_drv_t drv_nxt;

  // Input modes: 00/11 floating, 01 pull-down, 10 pull-up.
  // Output modes: 00 released, 01 drives high only, 10 low only, 11 both.
  always_comb begin
    drv_nxt = PIN_DRV_RST;
    if (ctl_in.force_hiz) begin
      drv_nxt = PIN_DRV_RST;
    end else if (ctl_in.dir_in || !HAS_OUTPUT) begin
      case (ctl_in.mode)
        MODE_PD_PCH: drv_nxt.pull_down = 1'b1;
        MODE_PU_NCH: drv_nxt.pull_up = 1'b1;
        default: drv_nxt = PIN_DRV_RST;
      endcase
    end else begin
      case (ctl_in.mode)
        MODE_PD_PCH: begin
          drv_nxt.out = 1'b1;
          drv_nxt.oe_n = ~ctl_in.out_lvl;
        end
        MODE_PU_NCH: begin
          drv_nxt.out = 1'b0;
          drv_nxt.oe_n = ctl_in.out_lvl;
        end
        MODE_CMOS: begin
          drv_nxt.out = ctl_in.out_lvl;
          drv_nxt.oe_n = 1'b0;
        end
        default: drv_nxt = PIN_DRV_RST;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drv_out <= PIN_DRV_RST;
    end else begin
      drv_out <= drv_nxt;
    end
  end

endmodule

// *** src/tpp_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Port has three pins: input-only, bidirectional, and one shared with test.
// - Pin-level register shows live levels of the three pins in bits 4:2.
// - Pin-level register is read-only and follows the pins, no fixed reset.
// - Test pin direction bit 4 resets to 1, input; 0 means output.
// - Bidirectional pin direction bit 3 resets to 0, output; 1 means input.
// - Input-only pin has no direction bit; bit 2 reads zero.
// - Input pins: code 00/11 floating, 01 pull-down, 10 pull-up.
// - Output pins: 00 floating, 01 P open drain, 10 N open drain, 11 CMOS.
// - Input-only pin uses the input coding and resets floating.
// - Mode-low register resets to 10h, mode-high register resets to 00h.
// - Mode-low register takes byte or 16-bit access covering both registers.
// - Crystal option forces input-only and bidirectional pins to floating input.
// - Crystal use is chosen only by the fixed option, never by registers.
module tpp_port import tpp_pkg::*; #(
  parameter int unsigned ADDR_W = BYTE_ADDR_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic input_only_pin_in,
  output logic input_only_pull_up_out,
  output logic input_only_pull_down_out,
  input wire logic bidir_pin_in,
  output logic bidir_pin_out,
  output logic bidir_pin_oe_n_out,
  output logic bidir_pull_up_out,
  output logic bidir_pull_down_out,
  input wire logic test_shared_pin_in,
  output logic test_shared_pin_out,
  output logic test_shared_pin_oe_n_out,
  output logic test_shared_pull_up_out,
  output logic test_shared_pull_down_out,
  input wire logic xtal_option_in,
  output logic crystal_select_out
);

  initial begin
    if (ADDR_W < BYTE_ADDR_W) begin
      $error("tpp_port: ADDR_W too narrow for the register map");
    end
  end

  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVELS =
    ADDR_W'(byte_addr(IDX_PIN_LEVELS));
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION =
    ADDR_W'(byte_addr(IDX_DIRECTION));
  localparam logic [ADDR_W-1:0] ADDR_MODE_LOW =
    ADDR_W'(byte_addr(IDX_MODE_LOW));
  localparam logic [ADDR_W-1:0] ADDR_MODE_HIGH =
    ADDR_W'(byte_addr(IDX_MODE_HIGH));
  localparam logic [ADDR_W-1:0] ADDR_DRIVE_LEVEL =
    ADDR_W'(byte_addr(IDX_DRIVE_LEVEL));
  localparam logic [ADDR_W-1:0] ADDR_STATUS =
    ADDR_W'(byte_addr(IDX_STATUS));

  // Register state
  logic [7:0] direction_r;
  logic [7:0] mode_low_r;
  logic [7:0] mode_high_r;
  logic [7:0] drive_level_r;
  logic xtal_sel_r;

  // Bus slave state
  tpp_apb_state_t apb_state_r;
  logic [31:0] rdata_r;
  logic ready_r;
  logic slverr_r;

  // Synchronised pin and strap levels
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic strap_sync;

  logic setup_phase;
  logic write_commit;
  logic byte0_wr;
  logic byte1_wr;

  tpp_pin_ctl_t input_ctl;
  tpp_pin_ctl_t bidir_ctl;
  tpp_pin_ctl_t test_ctl;
  tpp_pin_drv_t input_drv;
  tpp_pin_drv_t bidir_drv;
  tpp_pin_drv_t test_drv;

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == ADDR_PIN_LEVELS) || (a == ADDR_DIRECTION) ||
           (a == ADDR_MODE_LOW) || (a == ADDR_MODE_HIGH) ||
           (a == ADDR_DRIVE_LEVEL) || (a == ADDR_STATUS);
  endfunction

  function automatic logic [7:0] pin_mask(input logic [7:0] v);
    return v & PIN_FIELD_MASK;
  endfunction

  // Pin levels sit in register bits 4:2
  assign pin_raw = {test_shared_pin_in, bidir_pin_in, input_only_pin_in};

  tpp_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_in(clk_in),
    .async_in({xtal_option_in, pin_raw}),
    .sync_out({strap_sync, pin_sync})
  );

  // Crystal option is a strap caught while reset is held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xtal_sel_r <= strap_sync;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      crystal_select_out <= 1'b0;
    end else begin
      crystal_select_out <= xtal_sel_r;
    end
  end

  // APB handshake: a write lands only at the edge that sees pready high
  assign setup_phase = psel_in && !penable_in;
  assign write_commit = psel_in && penable_in && pready_out && pwrite_in;
  assign byte0_wr = write_commit && pstrb_in[0];
  assign byte1_wr = write_commit && pstrb_in[1];

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      apb_state_r <= APB_IDLE;
      ready_r <= 1'b0;
    end else begin
      case (apb_state_r)
        APB_IDLE: begin
          if (setup_phase) begin
            apb_state_r <= APB_ACCESS;
            ready_r <= 1'b1;
          end
        end
        APB_ACCESS: begin
          apb_state_r <= APB_IDLE;
          ready_r <= 1'b0;
        end
        default: begin
          apb_state_r <= APB_IDLE;
          ready_r <= 1'b0;
        end
      endcase
    end
  end

  // Read data and error are formed in the setup phase
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else if (setup_phase && apb_state_r == APB_IDLE) begin
      slverr_r <= !addr_known(paddr_in);
      rdata_r <= 32'h0000_0000;
      if (!pwrite_in) begin
        case (paddr_in)
          ADDR_PIN_LEVELS:
            rdata_r <= {24'h00_0000, 3'b000, pin_sync, 2'b00};
          ADDR_DIRECTION:
            rdata_r <= {24'h00_0000, pin_mask(direction_r)};
          ADDR_MODE_LOW:
            rdata_r <= {16'h0000, pin_mask(mode_high_r),
                        pin_mask(mode_low_r)};
          ADDR_MODE_HIGH:
            rdata_r <= {24'h00_0000, pin_mask(mode_high_r)};
          ADDR_DRIVE_LEVEL:
            rdata_r <= {24'h00_0000, pin_mask(drive_level_r)};
          ADDR_STATUS:
            rdata_r <= {31'h0000_0000, xtal_sel_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out <= rdata_r;
      pready_out <= ready_r;
      pslverr_out <= slverr_r;
    end
  end

  // Direction register; the input-only pin has no direction bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      direction_r <= DIRECTION_RST;
    end else if (byte0_wr && paddr_in == ADDR_DIRECTION) begin
      direction_r <= pwdata_in[7:0] & DIR_WRITE_MASK;
    end
  end

  // Mode-low register: byte lane 0 of its own word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_low_r <= MODE_LOW_RST;
    end else if (byte0_wr && paddr_in == ADDR_MODE_LOW) begin
      mode_low_r <= pin_mask(pwdata_in[7:0]);
    end
  end

  // Mode-high register: own word, or lane 1 of the mode-low word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_high_r <= MODE_HIGH_RST;
    end else if (byte1_wr && paddr_in == ADDR_MODE_LOW) begin
      mode_high_r <= pin_mask(pwdata_in[15:8]);
    end else if (byte0_wr && paddr_in == ADDR_MODE_HIGH) begin
      mode_high_r <= pin_mask(pwdata_in[7:0]);
    end
  end

  // Output levels for pins set to output
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_level_r <= DRIVE_LEVEL_RST;
    end else if (byte0_wr && paddr_in == ADDR_DRIVE_LEVEL) begin
      drive_level_r <= pwdata_in[7:0] & DRIVE_WRITE_MASK;
    end
  end

  // Per-pin control words
  always_comb begin
    input_ctl.force_hiz = xtal_sel_r;
    input_ctl.dir_in = 1'b1;
    input_ctl.mode = {mode_high_r[BIT_INPUT_PIN],
                      mode_low_r[BIT_INPUT_PIN]};
    input_ctl.out_lvl = 1'b0;

    bidir_ctl.force_hiz = xtal_sel_r;
    bidir_ctl.dir_in = direction_r[BIT_BIDIR_PIN];
    bidir_ctl.mode = {mode_high_r[BIT_BIDIR_PIN],
                      mode_low_r[BIT_BIDIR_PIN]};
    bidir_ctl.out_lvl = drive_level_r[BIT_BIDIR_PIN];

    // Output on the test pin is only reachable if software breaks the rule
    test_ctl.force_hiz = 1'b0;
    test_ctl.dir_in = direction_r[BIT_TEST_PIN];
    test_ctl.mode = {mode_high_r[BIT_TEST_PIN],
                     mode_low_r[BIT_TEST_PIN]};
    test_ctl.out_lvl = drive_level_r[BIT_TEST_PIN];
  end

  tpp_pin_drive #(
    .HAS_OUTPUT(1'b0)
  ) u_input_pin (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ctl_in(input_ctl),
    .drv_out(input_drv)
  );

  tpp_pin_drive #(
    .HAS_OUTPUT(1'b1)
  ) u_bidir_pin (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ctl_in(bidir_ctl),
    .drv_out(bidir_drv)
  );

  tpp_pin_drive #(
    .HAS_OUTPUT(1'b1)
  ) u_test_pin (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ctl_in(test_ctl),
    .drv_out(test_drv)
  );

  assign input_only_pull_up_out = input_drv.pull_up;
  assign input_only_pull_down_out = input_drv.pull_down;
  assign bidir_pin_out = bidir_drv.out;
  assign bidir_pin_oe_n_out = bidir_drv.oe_n;
  assign bidir_pull_up_out = bidir_drv.pull_up;
  assign bidir_pull_down_out = bidir_drv.pull_down;
  assign test_shared_pin_out = test_drv.out;
  assign test_shared_pin_oe_n_out = test_drv.oe_n;
  assign test_shared_pull_up_out = test_drv.pull_up;
  assign test_shared_pull_down_out = test_drv.pull_down;

endmodule

// *** verification/tpp_port_props.sv ***
`timescale 1ns/1ps
module tpp_port_props import tpp_pkg::*; #(
  parameter int unsigned ADDR_W = BYTE_ADDR_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic input_only_pull_up_out,
  input wire logic input_only_pull_down_out,
  input wire logic bidir_pin_oe_n_out,
  input wire logic bidir_pull_up_out,
  input wire logic bidir_pull_down_out,
  input wire logic crystal_select_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic setup;
  logic [ADDR_W-3:0] idx;
  assign setup = psel_in && !penable_in;
  assign idx = paddr_in[ADDR_W-1:2];

  property p_xtal_iso;
    crystal_select_out |-> !input_only_pull_up_out &&
      !input_only_pull_down_out && bidir_pin_oe_n_out &&
      !bidir_pull_up_out && !bidir_pull_down_out;
  endproperty
  a_xtal_iso: assert property (p_xtal_iso)
    else $error("crystal pins not floating");

  property p_xtal_stable;
    !$past(rst_in, 2) |-> $stable(crystal_select_out);
  endproperty
  a_xtal_stable: assert property (p_xtal_stable)
    else $error("crystal select moved");

  property p_dir_rd;
    setup && !pwrite_in && idx == IDX_DIRECTION |->
      ##2 pready_out && prdata_out[2] == 1'b0;
  endproperty
  a_dir_rd: assert property (p_dir_rd)
    else $error("direction bit 2 not zero");

  property p_unused_zero;
    pready_out && !pslverr_out && idx != IDX_STATUS |->
      prdata_out[31:13] == 19'h0 && prdata_out[9:5] == 5'h0 &&
      prdata_out[1:0] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bits not zero");

  property p_lvl_wr;
    setup && pwrite_in && idx == IDX_PIN_LEVELS |->
      ##2 pready_out && !pslverr_out;
  endproperty
  a_lvl_wr: assert property (p_lvl_wr)
    else $error("pin level write refused");

  property p_io_pulls;
    !(input_only_pull_up_out && input_only_pull_down_out);
  endproperty
  a_io_pulls: assert property (p_io_pulls)
    else $error("both pulls on");

  property p_bd_drv;
    !bidir_pin_oe_n_out |-> !bidir_pull_up_out && !bidir_pull_down_out;
  endproperty
  a_bd_drv: assert property (p_bd_drv)
    else $error("pull on while driving");

  property p_wr_mode;
    setup && pwrite_in && idx == IDX_MODE_LOW && pstrb_in[1:0] == 2'h3 &&
      pwdata_in[2] && !pwdata_in[10] && !crystal_select_out |->
      ##4 input_only_pull_down_out && !input_only_pull_up_out;
  endproperty
  a_wr_mode: assert property (p_wr_mode)
    else $error("pull-down code not applied");
endmodule

bind tpp_port tpp_port_props #(.ADDR_W(ADDR_W)) i_tpp_port_props (.*);

// *** verification/tpp_pin_model.sv ***
`timescale 1ns/1ps
module tpp_pin_model (
  input wire logic clk_in,
  input wire logic [2:0] oe_n_in,
  input wire logic [2:0] out_in,
  input wire logic [2:0] pu_in,
  input wire logic [2:0] pd_in,
  input wire logic [2:0] ext_en_in,
  input wire logic [2:0] ext_val_in,
  output logic [2:0] pin_out
);
  logic flip_r = 1'b0;
  always_ff @(posedge clk_in) begin
    flip_r <= ~flip_r;
  end
  // Device drive wins, then the outside driver, then pulls; floating wanders
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!oe_n_in[i]) pin_out[i] = out_in[i];
      else if (ext_en_in[i]) pin_out[i] = ext_val_in[i];
      else if (pu_in[i]) pin_out[i] = 1'b1;
      else if (pd_in[i]) pin_out[i] = 1'b0;
      else pin_out[i] = flip_r;
    end
  end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import tpp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [BYTE_ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [3:0] pstrb_in = '0;
  logic xtal_option_in = 1'b0;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] pins;
  logic [31:0] prdata_out, rd_d;
  logic pready_out, pslverr_out, rd_e, crystal_select_out, e_oe, e_out;
  logic input_only_pin_in, input_only_pull_up_out, input_only_pull_down_out;
  logic bidir_pin_in, bidir_pin_out, bidir_pin_oe_n_out;
  logic bidir_pull_up_out, bidir_pull_down_out;
  logic test_shared_pin_in, test_shared_pin_out, test_shared_pin_oe_n_out;
  logic test_shared_pull_up_out, test_shared_pull_down_out;
  logic [5:0] pulls;
  logic [2:0] drv;
  int bad_count = 0;
  int compares = 0;

  always #4 clk_in = ~clk_in;

  tpp_port i_tpp_port (.*);

  tpp_pin_model i_tpp_pin_model (
    .clk_in(clk_in),
    .oe_n_in({test_shared_pin_oe_n_out, bidir_pin_oe_n_out, 1'b1}),
    .out_in({test_shared_pin_out, bidir_pin_out, 1'b0}),
    .pu_in({test_shared_pull_up_out, bidir_pull_up_out,
      input_only_pull_up_out}),
    .pd_in({test_shared_pull_down_out, bidir_pull_down_out,
      input_only_pull_down_out}),
    .ext_en_in(3'h7),
    .ext_val_in(ext_val),
    .pin_out(pins)
  );
  assign {test_shared_pin_in, bidir_pin_in, input_only_pin_in} = pins;
  assign pulls = {input_only_pull_up_out, input_only_pull_down_out,
    bidir_pull_up_out, bidir_pull_down_out, test_shared_pull_up_out,
    test_shared_pull_down_out};
  assign drv = {test_shared_pin_oe_n_out, bidir_pin_oe_n_out,
    bidir_pin_oe_n_out ? 1'b0 : bidir_pin_out};

  task automatic final_report();
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [IDX_W-1:0] idx,
      input logic [31:0] d, input logic [3:0] s);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {idx, 2'b00};
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd_d = prdata_out;
    rd_e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'h0);
    chk(rd_d, exp);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'h3);
    repeat (3) @(posedge clk_in);
  endtask

  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask

  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  initial begin
    do_reset();
    chk(32'(test_shared_pull_down_out), 32'h1);
    chk(32'(pulls[5:4]), 32'h0);
    rdc(IDX_DIRECTION, 32'h10);
    rdc(IDX_MODE_LOW, 32'h0010);
    rdc(IDX_MODE_HIGH, 32'h0);
    for (int i = 0; i < 8; i++) begin
      ext_val <= 3'(i);
      repeat (4) @(posedge clk_in);
      rdc(IDX_PIN_LEVELS, 32'(i) << 2);
    end
    wr(IDX_PIN_LEVELS, 32'hff);
    chk(32'(rd_e), 32'h0);
    rdc(IDX_PIN_LEVELS, 32'h1c);
    wr(IDX_DIRECTION, 32'hff);
    rdc(IDX_DIRECTION, 32'h18);
    apb(1'b1, IDX_MODE_LOW, 32'h1c1c, 4'h1);
    rdc(IDX_MODE_LOW, 32'h001c);
    rdc(16'hf220, 32'h0);
    chk(32'(rd_e), 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MODE_LOW, {16'h0, c[1] ? 8'h1c : 8'h0, c[0] ? 8'h1c : 8'h0});
      chk(32'(pulls), 32'({3{c == 2, c == 1}}));
    end
    wr(IDX_DIRECTION, 32'h10);
    for (int v = 0; v < 2; v++) begin
      wr(IDX_DRIVE_LEVEL, v ? 32'h08 : 32'h00);
      for (int c = 0; c < 4; c++) begin
        wr(IDX_MODE_LOW, {16'h0, c[1] ? 8'h08 : 8'h0, c[0] ? 8'h08 : 8'h0});
        e_oe = c == 0 || (c == 1 && v == 0) || (c == 2 && v == 1);
        e_out = c == 1 ? 1'b1 : (c == 2 ? 1'b0 : v[0]);
        chk(32'(drv), 32'({1'b1, e_oe, !e_oe && e_out}));
        chk(32'(test_shared_pin_out), 32'h0);
      end
    end
    xtal_option_in <= 1'b1;
    do_reset();
    chk(32'(crystal_select_out), 32'h1);
    rdc(IDX_STATUS, 32'h1);
    wr(IDX_DIRECTION, 32'h18);
    wr(IDX_MODE_LOW, 32'h1c00);
    chk(32'(pulls), 32'h02);
    chk(32'(bidir_pin_oe_n_out), 32'h1);
    wr(IDX_STATUS, 32'h0);
    chk(32'(crystal_select_out), 32'h1);
    final_report();
  end
endmodule
